// File: hw/pioa_pkg.sv
// Summary of operation
// - Ninety-six lines form twelve ports of eight bits, each handled whole.
// - Any port outside the synchronous input set is read, and any port written, by host command, no external clock needed.
// - Up to twelve ports form a synchronous set running up to 256 transfers.
// - Each port keeps its last written or read value; a query returns it.
// - A configuration query reports tri-state mode, sync set, directions of ports 4..11 and enables of ports 0..3.
// - Handshake has a clock input and a busy output, up to 1 kHz.
// - Each port has its own tri-state control and external enable input 0..11.
// - Drivers follow software enable, hardware enable, or both, as selected.
// - Reset clears every software output enable, so all ports float.
// - Direction is chosen per whole port only.
// - Channels map in groups of eight: 1-8 port 0 up to 89-96 port 11.
// - Data bit 0 sits on the lowest channel of a port, bit 7 on the highest.
// - Writes to a disabled port are stored and driven once it is enabled.
// - After reset every port is asynchronous until placed in the set.
// - Asynchronous commands are refused while a synchronous run is armed.
package pioa_pkg;
   localparam int NPORTS = 12;
   localparam int PW     = 8;
   localparam int AW     = 6;
   localparam int DW     = 32;
   localparam int DEPTH  = 256;
   localparam int CW     = 9;
   // Register map, one 32-bit word per register
   localparam logic [AW-1:0] A_DATA0   = 6'h00; // Ports 0..11 at 0x00..0x0b
   localparam logic [AW-1:0] A_SWEN    = 6'h10; // Software enables [11:0]
   localparam logic [AW-1:0] A_DIR     = 6'h11; // 1 = output port
   localparam logic [AW-1:0] A_SYNC    = 6'h12; // 1 = port in synchronous set
   localparam logic [AW-1:0] A_TSMODE  = 6'h13; // [1:0] tri-state source
   localparam logic [AW-1:0] A_COUNT   = 6'h14; // Transfers 1..256 (0 = 256)
   localparam logic [AW-1:0] A_ARM     = 6'h15; // Write 1 arm, read status
   localparam logic [AW-1:0] A_LAST0   = 6'h20; // Last-value query 0x20..0x2b
   localparam logic [AW-1:0] A_CFG     = 6'h30; // Configuration summary
   localparam logic [AW-1:0] A_BUF     = 6'h31; // Head captured word, port 0 byte; read does not pop
   localparam logic [1:0] TS_SW   = 2'h0;
   localparam logic [1:0] TS_HW   = 2'h1;
   localparam logic [1:0] TS_BOTH = 2'h2;
   localparam logic [DW-1:0] D_ZERO = 32'h0000_0000;
   localparam logic [DW-1:0] D_BAD  = 32'hdead_beef;
   typedef enum logic [1:0] {
      PIOA_IDLE  = 2'b00,
      PIOA_ARMED = 2'b01,
      PIOA_BUSY  = 2'b10
   } pioa_state_t;
endpackage

// File: hw/pioa_top.sv
`timescale 1ns/100ps
module pioa_top (
   input  wire logic                                         core_clk_in,
   input  wire logic                                         rst_in,
   input  wire logic [pioa_pkg::AW-1:0]                      addr_in,
   input  wire logic [pioa_pkg::DW-1:0]                      wdata_in,
   input  wire logic                                         wr_in,
   input  wire logic                                         rd_in,
   output logic      [pioa_pkg::DW-1:0]                      rdata_out,
   output logic                                              refused_out,
   input  wire logic [pioa_pkg::NPORTS*pioa_pkg::PW-1:0]     io_channel_line_in,
   output logic      [pioa_pkg::NPORTS*pioa_pkg::PW-1:0]     io_channel_line_out,
   output logic      [pioa_pkg::NPORTS*pioa_pkg::PW-1:0]     io_channel_line_oe_n_out,
   input  wire logic [pioa_pkg::NPORTS-1:0]                  port_driver_enable_in,
   input  wire logic                                         handshake_clock_in,
   output logic                                              handshake_busy_out,
   output logic                                              cap_valid_out,
   input  wire logic                                         cap_ready_in
);
   import pioa_pkg::*;

   localparam int LW = NPORTS*PW;

   // Whole block state in one struct
   typedef struct packed {
      logic [LW-1:0]     dat;      // Written data per port
      logic [LW-1:0]     last;     // Last written or read value
      logic [NPORTS-1:0] swen;
      logic [NPORTS-1:0] dir;
      logic [NPORTS-1:0] sync;
      logic [1:0]        tsmode;
      logic [CW-1:0]     count;
      logic [CW-1:0]     done;
      pioa_state_t       st;
      logic [DW-1:0]     rdata;
      logic              refused;
      logic [LW-1:0]     pin_s1;
      logic [LW-1:0]     pin_s2;
      logic [NPORTS-1:0] hen_s1;
      logic [NPORTS-1:0] hen_s2;
      logic              hck_s1;
      logic              hck_s2;
      logic              hck_d;
      logic              busy;
      logic [1:0][LW-1:0] bw;      // Two-entry capture buffer
      logic [1:0]        bv;
      logic              bwp;
      logic              brp;
   } pioa_state_s_t;

   pioa_state_s_t r;
   pioa_state_s_t next_r;

   logic [NPORTS-1:0] drive;
   logic              clk_rise;
   logic [AW-1:0]     pidx;
   logic              in_data;
   logic              in_last;
   logic              buf_full;

   // Edge of the synchronised handshake clock, never of the raw pin
   assign clk_rise = r.hck_s2 & ~r.hck_d;
   assign pidx     = addr_in - A_DATA0;
   assign in_data  = (addr_in >= A_DATA0) && (addr_in < A_DATA0 + AW'(NPORTS));
   assign in_last  = (addr_in >= A_LAST0) && (addr_in < A_LAST0 + AW'(NPORTS));
   assign buf_full = &r.bv;

   // Per-port driver decision and pin mapping
   genvar g;
   generate
      for (g = 0; g < NPORTS; g++) begin : g_port
         always_comb begin
            unique case (r.tsmode)
               TS_SW:   drive[g] = r.swen[g];
               TS_HW:   drive[g] = r.hen_s2[g];
               TS_BOTH: drive[g] = r.swen[g] & r.hen_s2[g];
               default: drive[g] = 1'b0;
            endcase
         end
         // Bit 0 to the lowest channel of the port, whole port as one unit
         assign io_channel_line_out[g*PW +: PW]      = r.dat[g*PW +: PW];
         assign io_channel_line_oe_n_out[g*PW +: PW] =
            {PW{~(drive[g] & r.dir[g])}};
      end
   endgenerate

   assign rdata_out          = r.rdata;
   assign refused_out        = r.refused;
   assign handshake_busy_out = r.busy;
   assign cap_valid_out      = r.bv[r.brp];

   // Next-state logic: bus, synchroniser and synchronous transfer engine
   always_comb begin
      logic [3:0] p;
      logic       armed;
      p             = pidx[3:0];
      armed         = (r.st != PIOA_IDLE);
      next_r        = r;
      next_r.rdata  = D_ZERO;
      next_r.refused = 1'b0;
      next_r.pin_s1 = io_channel_line_in;
      next_r.pin_s2 = r.pin_s1;
      next_r.hen_s1 = port_driver_enable_in;
      next_r.hen_s2 = r.hen_s1;
      next_r.hck_s1 = handshake_clock_in;
      next_r.hck_s2 = r.hck_s1;
      next_r.hck_d  = r.hck_s2;

      // Outside reader drains the capture buffer
      if (r.bv[r.brp] && cap_ready_in) begin
         next_r.bv[r.brp] = 1'b0;
         next_r.brp       = ~r.brp;
      end

      // Register writes
      if (wr_in) begin
         if (in_data) begin
            if (armed) begin
               next_r.refused = 1'b1;
            end else begin
               // Stored even while the port floats; driven once enabled
               next_r.dat[p*PW +: PW]  = wdata_in[PW-1:0];
               next_r.last[p*PW +: PW] = wdata_in[PW-1:0];
            end
         end else if (armed && addr_in != A_ARM) begin
            next_r.refused = 1'b1;
         end else begin
            unique case (addr_in)
               A_SWEN:   next_r.swen   = wdata_in[NPORTS-1:0];
               A_DIR:    next_r.dir    = wdata_in[NPORTS-1:0];
               A_SYNC:   next_r.sync   = wdata_in[NPORTS-1:0];
               A_TSMODE: next_r.tsmode = wdata_in[1:0];
               A_COUNT:  next_r.count  = (wdata_in[CW-2:0] == '0) ?
                                         CW'(DEPTH) : {1'b0, wdata_in[CW-2:0]};
               A_ARM: begin
                  if (wdata_in[0] && r.st == PIOA_IDLE && r.sync != '0) begin
                     next_r.st   = PIOA_ARMED;
                     next_r.done = '0;
                  end else if (!wdata_in[0]) begin
                     next_r.st   = PIOA_IDLE; // Abort
                     next_r.busy = 1'b0;
                  end
               end
               default: next_r.refused = 1'b1;
            endcase
         end
      end

      // Register reads, answered one cycle later
      if (rd_in) begin
         if (in_data) begin
            if (armed || r.sync[p] && !r.dir[p]) begin
               next_r.refused = 1'b1;
            end else begin
               next_r.rdata = DW'(r.pin_s2[p*PW +: PW]);
               next_r.last[p*PW +: PW] = r.pin_s2[p*PW +: PW];
            end
         end else if (in_last) begin
            next_r.rdata = DW'(r.last[(addr_in - A_LAST0)*PW +: PW]);
         end else begin
            unique case (addr_in)
               A_SWEN:   next_r.rdata = DW'(r.swen);
               A_DIR:    next_r.rdata = DW'(r.dir);
               A_SYNC:   next_r.rdata = DW'(r.sync);
               A_TSMODE: next_r.rdata = DW'(r.tsmode);
               A_COUNT:  next_r.rdata = DW'(r.count);
               A_ARM:    next_r.rdata = DW'({r.done, r.st});
               A_CFG:    next_r.rdata = DW'({r.tsmode, r.sync,
                                             r.dir[NPORTS-1:4], r.swen[3:0]});
               A_BUF:    next_r.rdata = DW'(r.bw[r.brp][PW-1:0]);
               // Unmapped read: marker word plus the refusal pulse, so software sees it
               default: begin
                  next_r.rdata   = D_BAD;
                  next_r.refused = 1'b1;
               end
            endcase
         end
      end

      // Synchronous engine on handshake clock edges
      unique case (r.st)
         PIOA_IDLE: begin
            next_r.busy = 1'b0;
         end
         PIOA_ARMED, PIOA_BUSY: begin
            // Busy stalls the far side while the buffer cannot take a word
            next_r.busy = buf_full;
            if (clk_rise && !buf_full) begin
               next_r.st = PIOA_BUSY;
               for (int i = 0; i < NPORTS; i++) begin
                  if (r.sync[i] && !r.dir[i]) begin
                     next_r.last[i*PW +: PW] = r.pin_s2[i*PW +: PW];
                  end
               end
               next_r.bw[r.bwp] = r.pin_s2;
               next_r.bv[r.bwp] = 1'b1;
               next_r.bwp       = ~r.bwp;
               next_r.done      = r.done + CW'(1);
               if (r.done + CW'(1) >= r.count) begin
                  next_r.st   = PIOA_IDLE;
                  next_r.busy = 1'b0;
               end
            end
         end
         default: next_r.st = PIOA_IDLE;
      endcase

      // Abort written in the same cycle as a handshake edge wins, else the run resumes
      if (wr_in && addr_in == A_ARM && !wdata_in[0]) begin
         next_r.st   = PIOA_IDLE;
         next_r.busy = 1'b0;
      end
   end

   // State register; all ports asynchronous and floating after reset
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         r        <= '0;
         r.count  <= CW'(DEPTH);
         r.st     <= PIOA_IDLE;
      end else begin
         r <= next_r;
      end
   end
endmodule

// File: test/pioa_top_asserts.sv
`timescale 1ns/100ps
module pioa_chk (
   input wire logic                       core_clk_in,
   input wire logic                       rst_in,
   input wire logic [pioa_pkg::AW-1:0]    addr_in,
   input wire logic [pioa_pkg::DW-1:0]    wdata_in,
   input wire logic                       wr_in,
   input wire logic                       rd_in,
   input wire logic [pioa_pkg::DW-1:0]    rdata_out,
   input wire logic                       refused_out,
   input wire logic [95:0]                io_channel_line_out,
   input wire logic [95:0]                io_channel_line_oe_n_out
);
   import pioa_pkg::*;
   logic mixed;
   // Flags any port whose eight enables disagree; direction is per whole byte
   always_comb begin
      mixed = 1'b0;
      for (int p = 0; p < NPORTS; p++) begin
         mixed = mixed | (io_channel_line_oe_n_out[8*p+:8] != {8{io_channel_line_oe_n_out[8*p]}});
      end
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   property p_rd_quiet; !$past(rd_in) |-> rdata_out == '0; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
   property p_bad; rd_in && addr_in == 6'h3f |=> rdata_out == D_BAD && refused_out; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not flagged");
   property p_ref; refused_out |-> $past(rd_in || wr_in); endproperty
   a_ref: assert property (p_ref) else $error("refusal without access");
   property p_last; rd_in && addr_in == A_LAST0 |=> !refused_out; endproperty
   a_last: assert property (p_last) else $error("last value query refused");
   property p_cfg; rd_in && addr_in == A_CFG |=> !refused_out; endproperty
   a_cfg: assert property (p_cfg) else $error("config query refused");
   property p_whole; !mixed; endproperty
   a_whole: assert property (p_whole) else $error("port split in direction");
   property p_keep; wr_in && addr_in == A_DATA0 ##1 !refused_out ##1 rd_in && addr_in == A_LAST0
      |=> rdata_out[7:0] == $past(wdata_in[7:0], 3); endproperty
   a_keep: assert property (p_keep) else $error("written value lost");
   property p_lane; wr_in && addr_in == 6'h03 && wdata_in[7:0] == 8'h19 ##1 !refused_out
      |-> ##[0:2] io_channel_line_out[31:24] == 8'h19; endproperty
   a_lane: assert property (p_lane) else $error("port 3 lanes wrong");
endmodule
bind pioa_top pioa_chk i_pioa_chk (.*);

// File: test/pioa_far_model.sv
`timescale 1ns/100ps
module pioa_far_model (
   input  wire logic        run_in,
   input  wire logic [95:0] ext_in,
   input  wire logic [95:0] dev_in,
   input  wire logic [95:0] oe_n_in,
   output logic      [95:0] line_out,
   output logic             hs_clk_out
);
   // Equipment lets go of every line the device drives, so no line is fought over
   assign line_out = (oe_n_in & ext_in) | (~oe_n_in & dev_in);
   // Handshake clock runs only inside a frame and rests low between frames
   initial begin
      hs_clk_out = 1'b0;
      #3;
      forever begin
         #32;
         hs_clk_out = run_in ? ~hs_clk_out : 1'b0;
      end
   end
endmodule

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
   import pioa_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, run = 0, rdy = 0, ref_o, hs, busy, cv;
   logic [AW-1:0] a = '0;
   logic [DW-1:0] wd = '0, rdat;
   logic [95:0] ext = '0, lin, lout, oen, ev;
   logic [11:0] hw = '0, sw, en;
   int fails = 0, num_checks = 0, seed = 32'h42c2, mem[12], n;
   // Free-running core clock
   initial forever #2.5 clk = ~clk;
   pioa_top i_pioa_top (.core_clk_in(clk), .rst_in(rst), .addr_in(a), .wdata_in(wd),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .refused_out(ref_o),
      .io_channel_line_in(lin), .io_channel_line_out(lout), .io_channel_line_oe_n_out(oen),
      .port_driver_enable_in(hw), .handshake_clock_in(hs), .handshake_busy_out(busy),
      .cap_valid_out(cv), .cap_ready_in(rdy));
   pioa_far_model i_pioa_far_model (.run_in(run), .ext_in(ext), .dev_in(lout),
      .oe_n_in(oen), .line_out(lin), .hs_clk_out(hs));
   task automatic chk(input logic [95:0] g, input logic [95:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [AW-1:0] ad, input logic [DW-1:0] d);
      @(posedge clk);
      {wr, a, wd} <= {1'b1, ad, d};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd_reg(input logic [AW-1:0] ad);
      @(posedge clk);
      {rd, a} <= {1'b1, ad};
      @(posedge clk);
      rd <= 1'b0;
      #1;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_reg(A_CFG);
      chk(96'(rdat), '0);
      chk(oen, '1);
      for (int p = 0; p < 12; p++) begin
         mem[p] = p == 3 ? 8'h19 : $random(seed) & 8'hff;
         ev[8*p+:8] = mem[p][7:0];
         wr_reg(A_DATA0 + 6'(p), mem[p]);
         rd_reg(A_LAST0 + 6'(p));
         chk(96'(rdat), 96'(mem[p]));
      end
      chk(oen, '1);
      wr_reg(A_DIR, 32'hfff);
      wr_reg(A_SWEN, 32'hfff);
      repeat (6) @(posedge clk);
      chk(lout, ev);
      chk(oen, '0);
      for (int p = 0; p < 12; p++) begin
         rd_reg(A_DATA0 + 6'(p));
         chk(96'(rdat), 96'(mem[p]));
      end
      $display("async output test done");
      sw = 12'($random(seed));
      hw <= 12'($random(seed));
      wr_reg(A_SWEN, 32'(sw));
      // Code 3 names no enable source, so every port must float
      for (int m = 0; m < 4; m++) begin
         wr_reg(A_TSMODE, m);
         repeat (6) @(posedge clk);
         en = m == 0 ? sw : (m == 1 ? hw : (m == 2 ? sw & hw : 12'h000));
         for (int p = 0; p < 12; p++) ev[8*p+:8] = {8{~en[p]}};
         chk(oen, ev);
      end
      $display("tri-state test done");
      wr_reg(A_DIR, 32'h0);
      ext <= {$random(seed), $random(seed), $random(seed)};
      repeat (6) @(posedge clk);
      chk(oen, '1);
      for (int p = 0; p < 12; p++) begin
         rd_reg(A_DATA0 + 6'(p));
         chk(96'(rdat), 96'(ext[8*p+:8]));
      end
      rd_reg(6'h3f);
      chk(96'(rdat), 96'(D_BAD));
      chk(96'(ref_o), 96'h1);
      $display("async input test done");
      wr_reg(A_SYNC, 32'h1);
      rd_reg(A_CFG);
      chk(96'(rdat), 96'({2'h3, 12'h001, 8'h00, sw[3:0]}));
      wr_reg(A_COUNT, 32'h3);
      wr_reg(A_ARM, 32'h1);
      rd_reg(A_DATA0 + 6'h1);
      chk(96'(ref_o), 96'h1);
      // Fresh pin data, so the captures differ from what the async reads left behind
      ext <= {$random(seed), $random(seed), $random(seed)};
      run <= 1'b1;
      repeat (120) @(posedge clk);
      chk(96'(busy), 96'h1);
      run <= 1'b0;
      n = 0;
      // Bounded drain of the capture buffer while the handshake clock rests
      while (cv === 1'b1 && n < 8) begin
         rd_reg(A_BUF);
         chk(96'(rdat[7:0]), 96'(ext[7:0]));
         // Pop strobe launched on an edge; let the valid flag settle before looking again
         @(posedge clk);
         rdy <= 1'b1;
         @(posedge clk);
         rdy <= 1'b0;
         #1;
         n++;
      end
      chk(96'(n), 96'h2);
      rd_reg(A_LAST0);
      chk(96'(rdat), 96'(ext[7:0]));
      wr_reg(A_ARM, 32'h0);
      rd_reg(A_DATA0 + 6'h1);
      chk(96'(ref_o), 96'h0);
      chk(96'(rdat), 96'(ext[15:8]));
      $display("sync test done");
      // Reset again after the abort: enables clear, set empties, count back to full depth
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(oen, '1);
      chk(96'(busy), 96'h0);
      rd_reg(A_SYNC);
      chk(96'(rdat), 96'h0);
      rd_reg(A_COUNT);
      chk(96'(rdat), 96'(DEPTH));
      $display("reset test done");
      wrap_up();
   end
endmodule
